// ---- timer_capture_compare_unit.sv ----
// capture/compare unit with apb register access
// assumes timers run in the same clock domain; pin level fed back from the pad
module timer_capture_compare_unit (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] timer_a_count,
	input wire logic [15:0] timer_b_count,
	input wire logic pin_level,
	output logic compare_out,
	output logic compare_drive,
	output logic timer_a_reset,
	output logic adc_go_set,
	output logic ccp_event_flag,
	output logic ccp_irq
);
	typedef struct packed {
		logic [7:0] control;
		logic [15:0] value;
		logic flag;
		logic irq_en;
		logic timer_sel;
		logic [3:0] prescale;
		logic out_latch;
		logic match_last;
		logic [31:0] rdata;
		logic special;
	} unit_state_t;
	unit_state_t state;
	unit_state_t next_state;

	logic rise;
	logic fall;
	logic [3:0] mode;
	logic capturing;
	logic comparing;
	logic cap_event;
	logic match_now;
	logic match_pulse;
	logic [15:0] timer_sel_count;
	logic wr;
	logic rd;

	// pin level sampled whatever the direction
	ccu_edge_sync pin_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.pin(pin_level),
		.rise(rise),
		.fall(fall)
	);

	assign mode = state.control[3:0];
	assign capturing = mode[3:2] == 2'b01;
	assign comparing = mode == ccu_pkg::MODE_CMP_TOGGLE || mode[3:2] == 2'b10;
	assign timer_sel_count = state.timer_sel ? timer_b_count : timer_a_count;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;

	always_comb begin
		cap_event = 1'b0;
		case (mode)
			ccu_pkg::MODE_CAP_FALL: cap_event = fall;
			ccu_pkg::MODE_CAP_RISE: cap_event = rise;
			ccu_pkg::MODE_CAP_RISE4: cap_event = rise && state.prescale[1:0] == ccu_pkg::PRESCALE_4[1:0];
			ccu_pkg::MODE_CAP_RISE16: cap_event = rise && state.prescale == ccu_pkg::PRESCALE_16;
			default: cap_event = 1'b0;
		endcase
	end

	// continuous compare; one flag per match entry
	assign match_now = comparing && state.value == timer_sel_count;
	assign match_pulse = match_now & ~state.match_last;

	always_comb begin
		next_state = state;
		next_state.match_last = match_now;
		next_state.special = 1'b0;
		if (!capturing) begin
			next_state.prescale = 4'h0;
		end else if (rise) begin
			next_state.prescale = state.prescale + 4'h1;
		end
		if (wr && paddr == ccu_pkg::ADDR_VALUE_LOW && pstrb[0]) begin
			next_state.value[7:0] = pwdata[7:0];
		end
		if (wr && paddr == ccu_pkg::ADDR_VALUE_HIGH && pstrb[0]) begin
			next_state.value[15:8] = pwdata[7:0];
		end
		if (wr && paddr == ccu_pkg::ADDR_CONTROL && pstrb[0]) begin
			next_state.control = pwdata[7:0];
			if (pwdata[3:0] == ccu_pkg::MODE_OFF) begin
				next_state.out_latch = 1'b0;
			end
		end
		if (wr && paddr == ccu_pkg::ADDR_STATUS && pstrb[0]) begin
			if (pwdata[ccu_pkg::FLAG_BIT]) begin
				next_state.flag = 1'b0;
			end
			next_state.irq_en = pwdata[ccu_pkg::IRQ_EN_BIT];
			next_state.timer_sel = pwdata[ccu_pkg::TIMER_SEL_BIT];
		end
		if (cap_event) begin
			next_state.value = timer_sel_count;
		end
		if (match_pulse) begin
			case (mode)
				ccu_pkg::MODE_CMP_TOGGLE: next_state.out_latch = ~state.out_latch;
				ccu_pkg::MODE_CMP_SET: next_state.out_latch = 1'b1;
				ccu_pkg::MODE_CMP_CLEAR: next_state.out_latch = 1'b0;
				ccu_pkg::MODE_CMP_SPECIAL: next_state.special = 1'b1;
				default: next_state.out_latch = state.out_latch;
			endcase
		end
		// hardware set wins over software clear
		if (cap_event || match_pulse) begin
			next_state.flag = 1'b1;
		end
		next_state.rdata = 32'h0000_0000;
		if (rd) begin
			case (paddr)
				ccu_pkg::ADDR_VALUE_LOW: next_state.rdata = {24'h000000, state.value[7:0]};
				ccu_pkg::ADDR_VALUE_HIGH: next_state.rdata = {24'h000000, state.value[15:8]};
				ccu_pkg::ADDR_CONTROL: next_state.rdata = {24'h000000, state.control};
				ccu_pkg::ADDR_STATUS:
					next_state.rdata = {29'h0, state.timer_sel, state.irq_en, state.flag};
				default: next_state.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= '0;
			state.control <= ccu_pkg::CONTROL_RESET;
			state.value <= ccu_pkg::VALUE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign prdata = state.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == ccu_pkg::ADDR_VALUE_LOW
		|| paddr == ccu_pkg::ADDR_VALUE_HIGH || paddr == ccu_pkg::ADDR_CONTROL
		|| paddr == ccu_pkg::ADDR_STATUS);
	assign compare_out = state.out_latch;
	// soft-irq and special modes hand the pin back to the port
	assign compare_drive = comparing && mode != ccu_pkg::MODE_CMP_SOFT
		&& mode != ccu_pkg::MODE_CMP_SPECIAL;
	assign timer_a_reset = state.special;
	assign adc_go_set = state.special;
	assign ccp_event_flag = state.flag;
	assign ccp_irq = state.flag & state.irq_en;

	// the toggle needs the two-cycle relation of match and latch
	a_match_sets_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse |=> state.flag) else $error("match did not set flag");
	a_capture_loads_value: assert property (@(posedge core_clk) disable iff (!resetn)
		cap_event |=> state.value == $past(timer_sel_count)) else $error("capture lost");
	a_prescale_idle_zero: assert property (@(posedge core_clk) disable iff (!resetn)
		!capturing |=> state.prescale == 4'h0) else $error("prescaler kept");
	a_off_latch_low: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_OFF && !wr |=> !state.out_latch) else $error("latch not low");
	a_toggle_flips: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_TOGGLE && !wr
		|=> compare_out != $past(compare_out)) else $error("toggle missed");
	a_special_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_SPECIAL |=> timer_a_reset && adc_go_set)
		else $error("special trigger missing");
	a_soft_pin_kept: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_SOFT && !wr |=> $stable(compare_out))
		else $error("soft mode moved pin");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
		state.flag && !wr |=> state.flag) else $error("flag cleared by hardware");
	a_rise16_count: assert property (@(posedge core_clk) disable iff (!resetn)
		cap_event && mode == ccu_pkg::MODE_CAP_RISE16 |-> state.prescale == 4'hf)
		else $error("16th edge miscounted");

	// capture side: event choice, flag and overwrite
	a_capture_sets_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		cap_event |=> state.flag) else $error("capture left flag low");

	a_rise_captures: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_CAP_RISE && rise |=> state.value == $past(timer_sel_count))
		else $error("rising edge not captured");

	a_fall_captures: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_CAP_FALL && fall |=> state.value == $past(timer_sel_count))
		else $error("falling edge not captured");

	a_rise4_count: assert property (@(posedge core_clk) disable iff (!resetn)
		cap_event && mode == ccu_pkg::MODE_CAP_RISE4 |-> state.prescale[1:0] == 2'b11)
		else $error("4th edge miscounted");

	a_prescale_steps: assert property (@(posedge core_clk) disable iff (!resetn)
		capturing && rise |=> state.prescale == $past(state.prescale) + 4'h1)
		else $error("prescaler skipped a rise");

	a_no_capture_compare: assert property (@(posedge core_clk) disable iff (!resetn)
		comparing |-> !cap_event) else $error("capture in compare mode");

	a_capture_no_drive: assert property (@(posedge core_clk) disable iff (!resetn)
		capturing |-> !compare_drive) else $error("capture mode drives pin");

	// timer selection
	a_timer_a_used: assert property (@(posedge core_clk) disable iff (!resetn)
		!state.timer_sel |-> timer_sel_count == timer_a_count)
		else $error("timer a not selected");

	a_timer_b_used: assert property (@(posedge core_clk) disable iff (!resetn)
		state.timer_sel |-> timer_sel_count == timer_b_count)
		else $error("timer b not selected");

	// compare side: match, pin action and triggers
	a_match_equal: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse |-> state.value == timer_sel_count) else $error("match without equal");

	a_match_entry_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		comparing && state.value == timer_sel_count && !state.match_last |=> state.flag)
		else $error("match entry missed");

	a_match_once: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse |=> !match_pulse) else $error("match flagged twice");

	a_set_high: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_SET && !wr |=> compare_out)
		else $error("set mode left pin low");

	a_clear_low: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_CLEAR && !wr |=> !compare_out)
		else $error("clear mode left pin high");

	a_set_drives: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_CMP_SET |-> compare_drive) else $error("set mode not driving");

	a_soft_no_drive: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_CMP_SOFT |-> !compare_drive) else $error("soft mode drives pin");

	a_special_adc: assert property (@(posedge core_clk) disable iff (!resetn)
		match_pulse && mode == ccu_pkg::MODE_CMP_SPECIAL |=> adc_go_set)
		else $error("adc start missing");

	a_special_single: assert property (@(posedge core_clk) disable iff (!resetn)
		timer_a_reset |=> !timer_a_reset) else $error("timer reset too long");

	a_special_cause: assert property (@(posedge core_clk) disable iff (!resetn)
		timer_a_reset |-> $past(match_pulse)) else $error("timer reset without match");

	// off state and software access
	a_off_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
		mode == ccu_pkg::MODE_OFF |-> !cap_event && !match_pulse)
		else $error("event while off");

	a_off_write_low: assert property (@(posedge core_clk) disable iff (!resetn)
		wr && paddr == ccu_pkg::ADDR_CONTROL && pstrb[0] && pwdata[3:0] == ccu_pkg::MODE_OFF
		|=> !compare_out) else $error("off write kept latch");

	a_flag_sw_clear: assert property (@(posedge core_clk) disable iff (!resetn)
		wr && paddr == ccu_pkg::ADDR_STATUS && pstrb[0] && pwdata[ccu_pkg::FLAG_BIT]
		&& !cap_event && !match_pulse |=> !state.flag) else $error("flag not cleared");

	a_irq_gated: assert property (@(posedge core_clk) disable iff (!resetn)
		ccp_irq |-> state.irq_en && state.flag) else $error("irq not gated");

	a_irq_raised: assert property (@(posedge core_clk) disable iff (!resetn)
		state.flag && state.irq_en |-> ccp_irq) else $error("irq missing");

	a_read_flag: assert property (@(posedge core_clk) disable iff (!resetn)
		rd && paddr == ccu_pkg::ADDR_STATUS |=> prdata[0] == $past(state.flag))
		else $error("status read wrong");

	a_read_low: assert property (@(posedge core_clk) disable iff (!resetn)
		rd && paddr == ccu_pkg::ADDR_VALUE_LOW |=> prdata[7:0] == $past(state.value[7:0]))
		else $error("low byte read wrong");

	a_read_high: assert property (@(posedge core_clk) disable iff (!resetn)
		rd && paddr == ccu_pkg::ADDR_VALUE_HIGH |=> prdata[7:0] == $past(state.value[15:8]))
		else $error("high byte read wrong");
endmodule

// ---- ccu_pkg.sv ----
// constants for the timer capture/compare unit: register map, fields, modes
// assumes an apb slave at 32-bit data, one aligned word per register
//
// Behaviour
// - capture copies the whole 16-bit selected timer count into the value register
// - capture event: each falling, each rising, every 4th or every 16th rising edge
// - each capture sets the event flag; only software clears it
// - a new capture overwrites an unread earlier value, no overrun guard
// - edge detection watches the pin level even while the pin drives out
// - a status register bit (bit 2) selects timer a or timer b for the unit
// - prescaler counter held at zero when off or not capturing
// - prescale switch without going off keeps the count, may set the flag
// - compare mode continuously compares value register with the selected timer
// - on match drive high, low, toggle or keep pin; flag set same cycle
// - clearing control forces the compare output latch low
// - software-interrupt compare leaves pin, sets flag, raises irq when enabled
// - special event match resets the timer a count, acting as period register
// - special event also sets the adc go flag to start a conversion
// - capture codes: 0100 fall, 0101 rise, 0110 4th rise, 0111 16th rise
// - compare codes: 0010 toggle, 1000 set, 1001 clear, 1010 soft irq, 1011 special
// - mode 0000 turns the unit off and clears its prescaler and output latch; flag and value are kept
package ccu_pkg;
	localparam logic [11:0] ADDR_VALUE_LOW = 12'h000;
	localparam logic [11:0] ADDR_VALUE_HIGH = 12'h004;
	localparam logic [11:0] ADDR_CONTROL = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;
	// status: bit0 event flag (write 1 to clear), bit1 irq enable, bit2 timer b select
	localparam int FLAG_BIT = 0;
	localparam int IRQ_EN_BIT = 1;
	localparam int TIMER_SEL_BIT = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] VALUE_RESET = 16'h0000;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [3:0] PRESCALE_4 = 4'h3;
	localparam logic [3:0] PRESCALE_16 = 4'hf;
endpackage

// ---- ccu_edge_sync.sv ----
// pin synchroniser with rise and fall pulses
// assumes the pin may be asynchronous to core_clk
module ccu_edge_sync (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} sync_state_t;
	sync_state_t state;
	sync_state_t next_state;

	always_comb begin
		next_state.meta = pin;
		next_state.sync = state.meta;
		next_state.last = state.sync;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rise = state.sync & ~state.last;
	assign fall = ~state.sync & state.last;
endmodule

// ---- ccu_pin_model.sv ----
// pad model: external source level, or the unit's own drive fed back
// assumes the bench sets the source level between clock edges
module ccu_pin_model (
	input wire logic compare_out,
	input wire logic compare_drive,
	input wire logic src_level,
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// pad direction follows the unit's drive enable
	assign pin_level = compare_drive ? compare_out : src_level;
endmodule

// ---- timer_capture_compare_unit_tb.sv ----
// self-checking bench: apb master, pin source, timers in the core clock domain
// assumes a zero-wait apb slave; read results are scored from a queue
module timer_capture_compare_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
	logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, src_level = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = '0;
	logic [15:0] timer_a_count = '0, timer_b_count = '0, x, y, z, v;
	logic [31:0] prdata;
	logic pready, pslverr, pin_level, compare_out, compare_drive;
	logic timer_a_reset, adc_go_set, ccp_event_flag, ccp_irq;
	logic [32:0] expq [$];
	logic [32:0] got;
	logic [3:0] cm [5] = '{ccu_pkg::MODE_CMP_SET, ccu_pkg::MODE_CMP_CLEAR,
		ccu_pkg::MODE_CMP_TOGGLE, ccu_pkg::MODE_CMP_SOFT, ccu_pkg::MODE_CMP_SPECIAL};
	logic c_out [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic c_drv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	int n_fail = 0, cmp_count = 0, n_rst = 0, n_go = 0;
	always #5 core_clk = ~core_clk;
	timer_capture_compare_unit i_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_a_count(timer_a_count),
		.timer_b_count(timer_b_count), .pin_level(pin_level), .compare_out(compare_out),
		.compare_drive(compare_drive), .timer_a_reset(timer_a_reset),
		.adc_go_set(adc_go_set), .ccp_event_flag(ccp_event_flag), .ccp_irq(ccp_irq));
	ccu_pin_model i_pin (.compare_out(compare_out), .compare_drive(compare_drive),
		.src_level(src_level), .pin_level(pin_level));
	always @(posedge core_clk) begin
		if (psel && penable && pready && !pwrite && expq.size() > 0) begin
			got = expq.pop_front();
			`CHK({pslverr, prdata}, got)
		end
		if (timer_a_reset)
			n_rst++;
		if (adc_go_set)
			n_go++;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= 4'hf;
		if (!w)
			expq.push_back(e);
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_fail++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge core_clk);
	endtask
	// timers move only on core_clk edges
	// one rise then one fall, timers held well past the sync delay
	task automatic pulse(input logic [15:0] r, input logic [15:0] f);
		@(posedge core_clk);
		timer_a_count <= r;
		timer_b_count <= ~r;
		src_level <= 1'b1;
		repeat (5) @(posedge core_clk);
		timer_a_count <= f;
		timer_b_count <= ~f;
		src_level <= 1'b0;
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic match();
		@(posedge core_clk);
		timer_a_count <= v;
		repeat (2) @(posedge core_clk);
		timer_a_count <= v + 16'h0001;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	initial begin
		void'($urandom(32'hf54c34ca));
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		apb(1'b0, ccu_pkg::ADDR_CONTROL, 8'h00, {25'h0, ccu_pkg::CONTROL_RESET});
		apb(1'b0, 12'h010, 8'h00, {1'b1, 32'h0});
		for (int i = 0; i < 2; i++) begin
			x = $urandom;
			y = $urandom;
			apb(1'b1, ccu_pkg::ADDR_STATUS, {5'h00, i[0], 2'b11}, '0);
			apb(1'b1, ccu_pkg::ADDR_CONTROL, {4'h0, i ? ccu_pkg::MODE_CAP_RISE :
				ccu_pkg::MODE_CAP_FALL}, '0);
			pulse(x ^ 16'h0f0f, y ^ 16'h0f0f);
			`CHK(ccp_irq, 1'b1)
			pulse(x, y);
			z = i ? ~x : y;
			apb(1'b0, ccu_pkg::ADDR_VALUE_LOW, 8'h00, {25'h0, z[7:0]});
			apb(1'b0, ccu_pkg::ADDR_VALUE_HIGH, 8'h00, {25'h0, z[15:8]});
			`CHK(ccp_event_flag, 1'b1)
			// flag cleared after the value reads
			apb(1'b1, ccu_pkg::ADDR_STATUS, {5'h00, i[0], 2'b11}, '0);
			`CHK(ccp_event_flag, 1'b0)
		end
		for (int p = 0; p < 2; p++) begin
			// off before a new prescale mode
			apb(1'b1, ccu_pkg::ADDR_CONTROL, 8'h00, '0);
			apb(1'b1, ccu_pkg::ADDR_STATUS, 8'h03, '0);
			apb(1'b1, ccu_pkg::ADDR_CONTROL, {4'h0, p ? ccu_pkg::MODE_CAP_RISE16 :
				ccu_pkg::MODE_CAP_RISE4}, '0);
			for (int k = 1; k <= (p ? 16 : 4); k++) begin
				pulse(16'h0000, 16'h0000);
				`CHK(ccp_event_flag, k == (p ? 16 : 4))
			end
		end
		v = $urandom | 16'h0100;
		apb(1'b1, ccu_pkg::ADDR_CONTROL, 8'h00, '0);
		apb(1'b1, ccu_pkg::ADDR_VALUE_LOW, v[7:0], '0);
		apb(1'b1, ccu_pkg::ADDR_VALUE_HIGH, v[15:8], '0);
		apb(1'b0, ccu_pkg::ADDR_VALUE_LOW, 8'h00, {25'h0, v[7:0]});
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, ccu_pkg::ADDR_STATUS, 8'h03, '0);
			apb(1'b1, ccu_pkg::ADDR_CONTROL, {4'h0, cm[m]}, '0);
			match();
			`CHK(ccp_irq, 1'b1)
			`CHK(compare_drive, c_drv[m])
			if (m < 4)
				`CHK(compare_out, c_out[m])
		end
		`CHK(n_rst, 1)
		`CHK(n_go, 1)
		apb(1'b1, ccu_pkg::ADDR_CONTROL, 8'h00, '0);
		`CHK(compare_out, 1'b0)
		results();
	end
endmodule
